// ===== pcbd_regs.svh
`ifndef PCBD_REGS_SVH
`define PCBD_REGS_SVH
////////////////////////////////////////////////////////////////////////////////
// configuration dword indexes
`define PCBD_BAR0_IDX 6'h04
`define PCBD_CIS_IDX 6'h0a
`define PCBD_SUBSYS_IDX 6'h0b
`define PCBD_ROM_IDX 6'h0c
// base address field layout
`define PCBD_IO_LOW_MASK 32'h00000003
`define PCBD_MEM_LOW_MASK 32'h0000000f
`define PCBD_IO_MAX_MASK 32'hffffff00
`define PCBD_ROM_LOW_MASK 32'h000007ff
`define PCBD_ROM_MAX_MASK 32'hff000000
`define PCBD_IO_TYPE 32'h00000001
// card info pointer field positions
`define PCBD_CIS_SPACE_MSB 2
`define PCBD_CIS_OFS_LSB 3
`define PCBD_CIS_OFS_MSB 27
`define PCBD_CIS_IMG_LSB 28
// reset values
`define PCBD_WORD_RST 32'h00000000
`define PCBD_ROM_DEC_RST 1'b0
`endif

// ===== pcbd_pkg.sv
package pcbd_pkg;
  typedef logic [31:0] pcbd_word_t;
  typedef logic [5:0][31:0] pcbd_bars_t;
  // whole register state of the top module
  typedef struct packed {
    pcbd_bars_t bar_base;
    pcbd_word_t rom_base;
    logic rom_dec_on;
    pcbd_word_t rdata;
    logic rvalid;
    logic claim;
    logic [5:0] hit;
    logic rom_hit;
  } pcbd_state_s;
endpackage

// ===== pcbd_slot.sv
`timescale 1ns/1ns
`include "pcbd_regs.svh"
module pcbd_slot import pcbd_pkg::*; #(
  parameter logic [31:0] shape = 32'h00000000,
  parameter bit fixed_on = 1'b0,
  parameter logic [31:0] fixed_value = 32'h00000000,
  parameter bit is_rom = 1'b0
) (
  input wire pcbd_word_t base,
  input wire pcbd_word_t addr_in,
  input wire logic io_cycle,
  input wire logic mem_cycle,
  input wire logic io_space_on,
  input wire logic mem_space_on,
  input wire logic decode_on,
  output pcbd_word_t wr_mask,
  output pcbd_word_t read_value,
  output logic match
);
  localparam bit IMPL = shape != 32'h00000000;
  localparam bit IS_IO = !is_rom && shape[0];
  localparam logic [31:0] LOW = is_rom ? `PCBD_ROM_LOW_MASK :
    (IS_IO ? `PCBD_IO_LOW_MASK : `PCBD_MEM_LOW_MASK);
  localparam logic [31:0] MASK = shape & ~LOW;
  localparam logic [31:0] INV = ~MASK;
  localparam logic [31:0] TYPE = is_rom ? 32'h00000000 :
    (IS_IO ? `PCBD_IO_TYPE : (shape & `PCBD_MEM_LOW_MASK));

  ////////////////////////////////////////////////////////////////////////////
  // refuse shapes the decoder cannot serve
  if (IMPL && (MASK == 32'h00000000 || (INV & (INV + 32'h00000001)) != 0)) begin : g_c1
    $error("base shape must be ones from bit 31 down without gaps");
  end
  if (IMPL && IS_IO && (MASK & `PCBD_IO_MAX_MASK) != `PCBD_IO_MAX_MASK) begin : g_c2
    $error("io window above 256 bytes");
  end
  if (IMPL && IS_IO && shape[1]) begin : g_c3
    $error("io shape bit 1 must be zero");
  end
  if (IMPL && is_rom && (MASK & `PCBD_ROM_MAX_MASK) != `PCBD_ROM_MAX_MASK) begin : g_c4
    $error("rom window above 16 mbytes");
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable mask, readback and address compare
  pcbd_word_t base_used;
  assign base_used = fixed_on ? fixed_value : base;
  assign wr_mask = (IMPL && !fixed_on) ? MASK : 32'h00000000;
  assign read_value = IMPL ? ((base_used & MASK) | TYPE) : 32'h00000000;
  assign match = IMPL && decode_on && (IS_IO ? io_cycle : mem_cycle) &&
    (fixed_on || (IS_IO ? io_space_on : mem_space_on)) &&
    ((addr_in & MASK) == (base_used & MASK));
endmodule

// ===== pcbd_top.sv
`timescale 1ns/1ns
`include "pcbd_regs.svh"
module pcbd_top import pcbd_pkg::*; #(
  parameter int bar_count = 6,
  parameter pcbd_bars_t bar_shape = {
    32'h00000000,
    32'h00000000,
    32'h00000000,
    32'h00000000,
    32'hffffffc1,
    32'hffc00008
  },
  parameter logic [5:0] fixed_base_on = 6'h00,
  parameter pcbd_bars_t fixed_base_value = {6{32'h00000000}},
  parameter bit card_info_ptr_on = 1'b0,
  parameter logic [31:0] card_info_ptr_value = 32'h00000000,
  // arbitrary value
  parameter logic [15:0] card_maker_param = 16'h5a3c,
  // arbitrary value
  parameter logic [15:0] card_model_param = 16'h3c5a,
  parameter bit rom_on = 1'b0,
  parameter logic [31:0] rom_shape = 32'hfff00000,
  parameter bit rom_fixed_on = 1'b0,
  parameter logic [31:0] rom_fixed_value = 32'h00000000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [5:0] cfg_dw_index,
  input wire logic [3:0] cfg_be,
  input wire pcbd_word_t cfg_wdata,
  output pcbd_word_t cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_claim,
  input wire logic addr_valid,
  input wire pcbd_word_t addr_in,
  input wire logic io_cycle,
  input wire logic mem_cycle,
  input wire logic io_space_on,
  input wire logic mem_space_on,
  output logic [5:0] bar_hit,
  output logic exp_rom_hit
);
  ////////////////////////////////////////////////////////////////////////////
  // build checks
  if (bar_count < 1 || bar_count > 6) begin : g_cnt
    $error("bar_count must be 1 to 6");
  end
  if (rom_fixed_on && !rom_on) begin : g_romfix
    $error("fixed rom base needs rom_on");
  end

  ////////////////////////////////////////////////////////////////////////////
  // card info pointer fields
  localparam logic [2:0] CIS_SPACE = card_info_ptr_value[`PCBD_CIS_SPACE_MSB:0];
  localparam logic [24:0] CIS_OFS =
    card_info_ptr_value[`PCBD_CIS_OFS_MSB:`PCBD_CIS_OFS_LSB];
  localparam logic [3:0] rom_image_bits = card_info_ptr_value[31:`PCBD_CIS_IMG_LSB];
  localparam logic [31:0] CIS_WORD = card_info_ptr_on ?
    {rom_image_bits, CIS_OFS, CIS_SPACE} : 32'h00000000;
  localparam logic [15:0] card_maker_code = card_maker_param;
  localparam logic [15:0] card_model_code = card_model_param;
  localparam pcbd_state_s ST_RST = '{
    bar_base: {6{`PCBD_WORD_RST}},
    rom_base: `PCBD_WORD_RST,
    rom_dec_on: `PCBD_ROM_DEC_RST,
    rdata: `PCBD_WORD_RST,
    rvalid: 1'b0,
    claim: 1'b0,
    hit: 6'h00,
    rom_hit: 1'b0
  };

  pcbd_state_s st;
  pcbd_state_s next_st;
  pcbd_bars_t bar_mask;
  pcbd_bars_t bar_read;
  logic [5:0] slot_match;
  pcbd_word_t rom_mask;
  pcbd_word_t rom_read;
  logic rom_match;
  pcbd_word_t lane;
  pcbd_word_t read_word;
  logic read_known;

  ////////////////////////////////////////////////////////////////////////////
  // one decoder slot per base address register
  for (genvar g = 0; g < 6; g++) begin : g_bar
    localparam logic [31:0] SHAPE = (g < bar_count) ? bar_shape[g] : 32'h00000000;
    pcbd_slot #(
      .shape(SHAPE),
      .fixed_on(fixed_base_on[g]),
      .fixed_value(fixed_base_value[g]),
      .is_rom(1'b0)
    ) u_slot (
      .base(st.bar_base[g]),
      .addr_in(addr_in),
      .io_cycle(io_cycle),
      .mem_cycle(mem_cycle),
      .io_space_on(io_space_on),
      .mem_space_on(mem_space_on),
      .decode_on(1'b1),
      .wr_mask(bar_mask[g]),
      .read_value(bar_read[g]),
      .match(slot_match[g])
    );
  end

  // expansion rom slot, absent unless rom_on
  pcbd_slot #(
    .shape(rom_on ? rom_shape : 32'h00000000),
    .fixed_on(rom_fixed_on),
    .fixed_value(rom_fixed_value),
    .is_rom(1'b1)
  ) u_rom (
    .base(st.rom_base),
    .addr_in(addr_in),
    .io_cycle(io_cycle),
    .mem_cycle(mem_cycle),
    .io_space_on(io_space_on),
    .mem_space_on(mem_space_on),
    .decode_on(st.rom_dec_on),
    .wr_mask(rom_mask),
    .read_value(rom_read),
    .match(rom_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // byte lanes of a configuration write
  always_comb begin
    lane = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  end

  // configuration read multiplexer
  always_comb begin
    read_word = 32'h00000000;
    read_known = 1'b1;
    case (cfg_dw_index)
      `PCBD_CIS_IDX: begin
        read_word = CIS_WORD;
      end
      `PCBD_SUBSYS_IDX: begin
        read_word = {card_model_code, card_maker_code};
      end
      `PCBD_ROM_IDX: begin
        if (rom_on) begin
          read_word = rom_read | {31'h00000000, st.rom_dec_on};
        end
      end
      default: begin
        read_known = 1'b0;
        for (int i = 0; i < 6; i++) begin
          if (cfg_dw_index == `PCBD_BAR0_IDX + 6'(i)) begin
            read_word = bar_read[i];
            read_known = 1'b1;
          end
        end
      end
    endcase
  end

  // next state: writes, read answer and hit capture
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.claim = 1'b0;
    next_st.hit = 6'h00;
    next_st.rom_hit = 1'b0;
    if (cfg_wr) begin
      for (int i = 0; i < 6; i++) begin
        if (cfg_dw_index == `PCBD_BAR0_IDX + 6'(i)) begin
          next_st.bar_base[i] = (st.bar_base[i] & ~(lane & bar_mask[i])) |
            (cfg_wdata & lane & bar_mask[i]);
        end
      end
      if (rom_on && cfg_dw_index == `PCBD_ROM_IDX) begin
        next_st.rom_base = (st.rom_base & ~(lane & rom_mask)) |
          (cfg_wdata & lane & rom_mask);
        if (cfg_be[0]) begin
          next_st.rom_dec_on = cfg_wdata[0];
        end
      end
    end
    if (cfg_rd) begin
      next_st.rvalid = 1'b1;
      next_st.claim = read_known;
      next_st.rdata = read_word;
    end
    if (addr_valid) begin
      next_st.hit = slot_match;
      next_st.rom_hit = rom_match;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  assign cfg_claim = st.claim;
  assign bar_hit = st.hit;
  assign exp_rom_hit = st.rom_hit;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_size_probe(logic [5:0] idx);
    cfg_wr && cfg_dw_index == idx && cfg_be == 4'hf && cfg_wdata == 32'hffffffff;
  endsequence

  sequence s_read_back(logic [5:0] idx);
    cfg_rd && !cfg_wr && cfg_dw_index == idx;
  endsequence

  sequence s_rom_probe;
    addr_valid && mem_cycle;
  endsequence

  sequence s_rom_write;
    cfg_wr && cfg_dw_index == `PCBD_ROM_IDX && cfg_be[0];
  endsequence

  // writable rom base bits as the shape gives them
  localparam logic [31:0] ROM_MASK = rom_shape & ~`PCBD_ROM_LOW_MASK;

  for (genvar g = 0; g < 6; g++) begin : g_chk
    localparam logic [5:0] IDX = `PCBD_BAR0_IDX + 6'(g);
    localparam logic [31:0] SHAPE = (g < bar_count) ? bar_shape[g] : 32'h00000000;
    localparam logic [31:0] LOW = SHAPE[0] ? `PCBD_IO_LOW_MASK : `PCBD_MEM_LOW_MASK;
    localparam logic [31:0] TYPE = SHAPE[0] ? `PCBD_IO_TYPE : (SHAPE & LOW);
    localparam logic [31:0] FIXED_RD =
      (fixed_base_value[g] & SHAPE & ~LOW) | TYPE;
    localparam logic [31:0] MASK = SHAPE & ~LOW;

    a_bar_type_bit: assert property (
      s_read_back(IDX) |=> cfg_rvalid && cfg_rdata[0] == SHAPE[0])
      else $error("bar type bit wrong");

    a_io_resv_bit: assert property (
      s_read_back(IDX) ##0 (SHAPE[0] == 1'b1) |=> cfg_rdata[1] == 1'b0)
      else $error("io reserved bit not zero");

    a_low_bits_zero: assert property (
      s_read_back(IDX) |=> (cfg_rdata & ~(SHAPE | TYPE)) == 32'h00000000)
      else $error("bits under writable field not zero");

    a_size_probe: assert property (
      s_size_probe(IDX) ##1 !cfg_wr ##1 s_read_back(IDX) ##0 (fixed_base_on[g] == 1'b0)
      |=> cfg_rdata == SHAPE)
      else $error("sizing readback wrong");

    a_fixed_read: assert property (
      s_read_back(IDX) ##0 (fixed_base_on[g] == 1'b1 && SHAPE != 0)
      |=> cfg_rdata == FIXED_RD)
      else $error("fixed base readback wrong");

    a_hit_cause: assert property (
      bar_hit[g] == ($past(addr_valid) && $past(slot_match[g])))
      else $error("bar hit not tied to decode");

    a_space_gate: assert property (
      addr_valid && !fixed_base_on[g] && !(SHAPE[0] ? io_space_on : mem_space_on)
      |=> !bar_hit[g])
      else $error("bar hit with space disabled");

    a_fixed_hit: assert property (
      addr_valid && fixed_base_on[g] && SHAPE != 32'h00000000 &&
      (SHAPE[0] ? io_cycle : mem_cycle) && (addr_in & MASK) == (fixed_base_value[g] & MASK)
      |=> bar_hit[g])
      else $error("fixed base not claimed");

    a_hit_type: assert property (
      bar_hit[g] |-> (SHAPE[0] ? $past(io_cycle) : $past(mem_cycle)))
      else $error("bar hit on wrong cycle type");

    a_hit_window: assert property (
      bar_hit[g] |-> (($past(addr_in) ^ (fixed_base_on[g] ? fixed_base_value[g] :
      $past(st.bar_base[g]))) & MASK) == 32'h00000000)
      else $error("bar hit outside its window");
  end

  a_card_info: assert property (
    s_read_back(`PCBD_CIS_IDX) |=> cfg_rvalid && cfg_claim && cfg_rdata == CIS_WORD)
    else $error("card info pointer wrong");

  a_subsys_codes: assert property (
    s_read_back(`PCBD_SUBSYS_IDX) |=> cfg_rdata == {card_model_param, card_maker_param})
    else $error("subsystem codes wrong");

  a_rom_disabled: assert property (
    s_rom_probe ##0 !st.rom_dec_on |=> !exp_rom_hit)
    else $error("rom hit while decode off");

  a_rom_resv: assert property (
    s_read_back(`PCBD_ROM_IDX) |=> cfg_rdata[10:1] == 10'h000)
    else $error("rom reserved bits not zero");

  a_rom_absent: assert property (
    !rom_on |-> !exp_rom_hit && !st.rom_dec_on)
    else $error("rom active while absent");

  a_rom_dec_write: assert property (
    s_rom_write ##0 rom_on |=> st.rom_dec_on == $past(cfg_wdata[0]))
    else $error("rom decode bit not written");

  a_rom_dec_hold: assert property (
    !(cfg_wr && cfg_dw_index == `PCBD_ROM_IDX && cfg_be[0]) |=> $stable(st.rom_dec_on))
    else $error("rom decode bit changed without a write");

  a_rom_read_dec: assert property (
    s_read_back(`PCBD_ROM_IDX) ##0 rom_on |=> cfg_rdata[0] == $past(st.rom_dec_on))
    else $error("rom decode bit readback wrong");

  a_rom_fixed_read: assert property (
    s_read_back(`PCBD_ROM_IDX) ##0 (rom_on && rom_fixed_on)
    |=> (cfg_rdata & ~`PCBD_ROM_LOW_MASK) == (rom_fixed_value & ROM_MASK))
    else $error("fixed rom base readback wrong");

  a_rom_read_zero: assert property (
    s_read_back(`PCBD_ROM_IDX) |=> (cfg_rdata & ~ROM_MASK & 32'hfffffffe) == 32'h00000000)
    else $error("rom bits under the base field not zero");

  a_rom_window: assert property (
    exp_rom_hit |-> (($past(addr_in) ^ (rom_fixed_on ? rom_fixed_value : $past(st.rom_base)))
    & ROM_MASK) == 32'h00000000)
    else $error("rom hit outside its window");

  a_rom_cause: assert property (
    exp_rom_hit |-> rom_on && $past(st.rom_dec_on) && $past(mem_cycle) && $past(addr_valid))
    else $error("rom hit without an enabled rom window");

  a_read_answer: assert property (
    cfg_rvalid == $past(cfg_rd))
    else $error("read answer missing or extra");

  a_unknown_idx: assert property (
    cfg_rd && (cfg_dw_index < `PCBD_BAR0_IDX || cfg_dw_index > `PCBD_ROM_IDX)
    |=> cfg_rvalid && !cfg_claim && cfg_rdata == 32'h00000000)
    else $error("unknown index claimed");
endmodule

// ===== pcbd_host.sv
`timescale 1ns/1ns
module pcbd_host import pcbd_pkg::*; (
  input wire logic clock,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [5:0] cfg_dw_index,
  output logic [3:0] cfg_be,
  output pcbd_word_t cfg_wdata,
  input wire pcbd_word_t cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic cfg_claim,
  output logic addr_valid,
  output pcbd_word_t addr_in,
  output logic io_cycle,
  output logic mem_cycle
);
  // idle bus at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_dw_index = 6'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
    addr_valid = 1'b0;
    addr_in = 32'h00000000;
    io_cycle = 1'b0;
    mem_cycle = 1'b0;
  end
  // one write pulse; released data lines flip so stale values never match
  task automatic cfg_write(input logic [5:0] idx, input logic [3:0] be, input pcbd_word_t d);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_dw_index <= idx;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // one read pulse; answer stands in the cycle after the taking edge
  task automatic cfg_read(input logic [5:0] idx, output pcbd_word_t d, output logic ok,
                          output logic cl);
    @(posedge clock);
    cfg_rd <= 1'b1;
    cfg_dw_index <= idx;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
    ok = cfg_rvalid;
    cl = cfg_claim;
  endtask
  // one address phase strobe
  task automatic decode(input pcbd_word_t a, input logic io, input logic mem);
    @(posedge clock);
    addr_valid <= 1'b1;
    addr_in <= a;
    io_cycle <= io;
    mem_cycle <= mem;
    @(posedge clock);
    addr_valid <= 1'b0;
    addr_in <= ~a;
    #1;
  endtask
endmodule

// ===== pcbd_top_tb.sv
`timescale 1ns/1ns
module pcbd_top_tb import pcbd_pkg::*;;
  logic clock;
  logic rst_n;
  logic io_space_on;
  logic mem_space_on;
  logic cfg_wr;
  logic cfg_rd;
  logic cfg_rvalid;
  logic cfg_claim;
  logic addr_valid;
  logic io_cycle;
  logic mem_cycle;
  logic exp_rom_hit;
  logic [5:0] cfg_dw_index;
  logic [5:0] bar_hit;
  logic [3:0] cfg_be;
  pcbd_word_t cfg_wdata;
  pcbd_word_t cfg_rdata;
  pcbd_word_t addr_in;
  pcbd_word_t fx_rdata;
  pcbd_word_t bare_rdata;
  logic fx_rvalid;
  logic fx_claim;
  logic fx_rom_hit;
  logic bare_rvalid;
  logic bare_claim;
  logic bare_rom_hit;
  logic [5:0] fx_bar_hit;
  logic [5:0] bare_bar_hit;
  int mismatches = 0;
  int n_checks = 0;
  typedef struct {
    logic [5:0] idx;
    logic [3:0] be;
    pcbd_word_t d;
    pcbd_word_t exp;
    logic cl;
  } pcbd_row_s;
  // write (be nonzero) then read back; be zero means read only
  pcbd_row_s rows [8] = '{
    '{6'h0b, 4'h0, 32'h0, 32'h3c5a5a3c, 1'b1},
    '{6'h0a, 4'h0, 32'h0, 32'h1234567a, 1'b1},
    '{6'h04, 4'hf, 32'hffffffff, 32'hffc00008, 1'b1},
    '{6'h04, 4'h8, 32'h0, 32'h00c00008, 1'b1},
    '{6'h05, 4'hf, 32'hffffffff, 32'hffffffc1, 1'b1},
    '{6'h06, 4'hf, 32'hffffffff, 32'h0000a501, 1'b1},
    '{6'h0c, 4'hf, 32'hffffffff, 32'hfff00001, 1'b1},
    '{6'h3f, 4'hf, 32'hffffffff, 32'h0, 1'b0}
  };
  // bar0 memory, bar1 io 64 bytes, bar2 fixed io, rom on
  pcbd_top #(
    .bar_shape({32'h0, 32'h0, 32'h0, 32'hffffff01, 32'hffffffc1, 32'hffc00008}),
    .fixed_base_on(6'h04),
    .fixed_base_value({96'h0, 32'h0000a500, 64'h0}),
    .card_info_ptr_on(1'b1),
    .card_info_ptr_value(32'h1234567a),
    .rom_on(1'b1)
  ) pcbd_top_inst (
    .clock, .rst_n, .cfg_wr, .cfg_rd, .cfg_dw_index, .cfg_be, .cfg_wdata, .cfg_rdata,
    .cfg_rvalid, .cfg_claim, .addr_valid, .addr_in, .io_cycle, .mem_cycle,
    .io_space_on, .mem_space_on, .bar_hit, .exp_rom_hit
  );
  pcbd_host pcbd_host_inst (
    .clock, .cfg_wr, .cfg_rd, .cfg_dw_index, .cfg_be, .cfg_wdata, .cfg_rdata,
    .cfg_rvalid, .cfg_claim, .addr_valid, .addr_in, .io_cycle, .mem_cycle
  );
  // second build on the same bus: fixed rom base, bar0 only, no card info pointer
  if (1) begin : g_fx
    pcbd_top #(
      .bar_count(1),
      .rom_on(1'b1),
      .rom_fixed_on(1'b1),
      .rom_fixed_value(32'h00500000)
    ) pcbd_top_inst (
      .clock, .rst_n, .cfg_wr, .cfg_rd, .cfg_dw_index, .cfg_be, .cfg_wdata,
      .cfg_rdata(fx_rdata), .cfg_rvalid(fx_rvalid), .cfg_claim(fx_claim),
      .addr_valid, .addr_in, .io_cycle, .mem_cycle, .io_space_on, .mem_space_on,
      .bar_hit(fx_bar_hit), .exp_rom_hit(fx_rom_hit)
    );
  end
  // third build with every parameter at its default: rom absent
  if (1) begin : g_bare
    pcbd_top pcbd_top_inst (
      .clock, .rst_n, .cfg_wr, .cfg_rd, .cfg_dw_index, .cfg_be, .cfg_wdata,
      .cfg_rdata(bare_rdata), .cfg_rvalid(bare_rvalid), .cfg_claim(bare_claim),
      .addr_valid, .addr_in, .io_cycle, .mem_cycle, .io_space_on, .mem_space_on,
      .bar_hit(bare_bar_hit), .exp_rom_hit(bare_rom_hit)
    );
  end
  ////////////////////////////////////////////////////////////////////////////////
  // clock source
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // compare and count
  task automatic check(input string nm, input pcbd_word_t seen, input pcbd_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // read one dword and compare answer, claim and data
  task automatic rd(input logic [5:0] idx, input pcbd_word_t exp, input logic cl);
    pcbd_word_t d;
    logic ok;
    logic c;
    pcbd_host_inst.cfg_read(idx, d, ok, c);
    check("cfg_rvalid", {31'h0, ok}, 32'h1);
    check("cfg_claim", {31'h0, c}, {31'h0, cl});
    check("cfg_rdata", d, exp);
  endtask
  // one address phase, hits compared one cycle later
  task automatic dc(input pcbd_word_t a, input logic io, input logic mem, input logic [6:0] e);
    pcbd_host_inst.decode(a, io, mem);
    check("hits", {25'h0, exp_rom_hit, bar_hit}, {25'h0, e});
  endtask
  // read on the shared bus and compare the answers of the two extra builds
  task automatic rd_alt(input logic [5:0] idx, input pcbd_word_t e_fx, input pcbd_word_t e_bare);
    pcbd_word_t d;
    logic ok;
    logic c;
    pcbd_host_inst.cfg_read(idx, d, ok, c);
    check("fx_rvalid", {31'h0, fx_rvalid}, 32'h1);
    check("fx_claim", {31'h0, fx_claim}, 32'h1);
    check("fx_rdata", fx_rdata, e_fx);
    check("bare_rvalid", {31'h0, bare_rvalid}, 32'h1);
    check("bare_claim", {31'h0, bare_claim}, 32'h1);
    check("bare_rdata", bare_rdata, e_bare);
  endtask
  // memory address phase, hits of the two extra builds compared one cycle later
  task automatic dc_alt(input pcbd_word_t a, input logic [6:0] e_fx, input logic [6:0] e_bare);
    pcbd_host_inst.decode(a, 1'b0, 1'b1);
    check("fx_hits", {25'h0, fx_rom_hit, fx_bar_hit}, {25'h0, e_fx});
    check("bare_hits", {25'h0, bare_rom_hit, bare_bar_hit}, {25'h0, e_bare});
  endtask
  // verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    io_space_on = 1'b1;
    mem_space_on = 1'b1;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].be != 4'h0)
        pcbd_host_inst.cfg_write(rows[i].idx, rows[i].be, rows[i].d);
      rd(rows[i].idx, rows[i].exp, rows[i].cl);
    end
    // program windows and decode against them
    pcbd_host_inst.cfg_write(6'h04, 4'hf, 32'h12400000);
    pcbd_host_inst.cfg_write(6'h05, 4'hf, 32'h0000a0c0);
    pcbd_host_inst.cfg_write(6'h0c, 4'hf, 32'h00300001);
    dc(32'h12412344, 1'b0, 1'b1, 7'h01);
    dc(32'h12800000, 1'b0, 1'b1, 7'h00);
    dc(32'h0000a0c5, 1'b1, 1'b0, 7'h02);
    dc(32'h00345678, 1'b0, 1'b1, 7'h40);
    io_space_on <= 1'b0;
    mem_space_on <= 1'b0;
    dc(32'h0000a510, 1'b1, 1'b0, 7'h04);
    dc(32'h12412344, 1'b0, 1'b1, 7'h00);
    mem_space_on <= 1'b1;
    // decode bit cleared through lane zero only
    pcbd_host_inst.cfg_write(6'h0c, 4'h1, 32'h00000000);
    dc(32'h00345678, 1'b0, 1'b1, 7'h00);
    rd(6'h0c, 32'h00300000, 1'b1);
    // reset in mid-run clears bases and the decode bit
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(6'h04, 32'h00000008, 1'b1);
    rd(6'h0c, 32'h00000000, 1'b1);
    rd(6'h06, 32'h0000a501, 1'b1);
    // fixed rom base build and default build
    rd_alt(6'h0c, 32'h00500000, 32'h00000000);
    rd_alt(6'h0a, 32'h00000000, 32'h00000000);
    rd_alt(6'h0b, 32'h3c5a5a3c, 32'h3c5a5a3c);
    pcbd_host_inst.cfg_write(6'h0c, 4'hf, 32'hffffffff);
    rd_alt(6'h0c, 32'h00500001, 32'h00000000);
    dc_alt(32'h00012345, 7'h01, 7'h01);
    dc_alt(32'h00512345, 7'h40, 7'h00);
    mem_space_on <= 1'b0;
    dc_alt(32'h00598765, 7'h40, 7'h00);
    test_done();
  end
  // watchdog well beyond the ninety or so cycles of the run
  initial begin
    #(8 * 5000);
    mismatches++;
    test_done();
  end
endmodule
